// ### src/core_power_state_signalling.v
// Power-state register bits, their mirror outputs and wait-for-interrupt sleep
// Function
// - Low-power output follows status bit 27
// - Exception-level output follows status bit 1
// - Error-level output follows status bit 2
// - Debug-mode output follows debug bit 30
// - Wait stops core clock; wake inputs stay live
// - Interrupt, NMI or reset ends wait halt
// - Sleep output raised when wait executes
// - Static design; clock may slow or stop
`timescale 1ns/100ps
`default_nettype none
`include "power_state_defs.vh"

module core_power_state_signalling #(
  parameter INT_COUNT = 6
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 reset_n,
  // Wake sources, sampled while halted
  input  wire [INT_COUNT-1:0] interruptIn,
  input  wire                 nmiIn,
  input  wire                 cold_reset_in,
  // AXI4-Lite write address
  input  wire [3:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // Power-state outputs to the system agent
  output wire                 low_power_request_out,
  output wire                 exception_level_out,
  output wire                 error_level_out,
  output wire                 debug_mode_out,
  output wire                 sleepOut,
  output wire                 coreClockEnable
);

  localparam RUN   = 1'b0;
  localparam HALT  = 1'b1;

  reg  [31:0] status_reg;
  reg  [31:0] debugCtl_reg;
  reg         state_reg;
  reg         awHeld_reg;
  reg  [3:0]  awAddr_reg;
  reg         wHeld_reg;
  reg  [31:0] wData_reg;
  reg  [3:0]  wStrb_reg;

  wire        wakeEvent;
  wire        doWrite;
  wire        waitCmd;
  wire [31:0] wMerged;

  // Byte-lane merge of write data into an old register value
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  // Address and data may arrive in either order; hold each until both
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        awNow   = awHeld_reg | (s_axi_awvalid & s_axi_awready);
  wire        wNow    = wHeld_reg | (s_axi_wvalid & s_axi_wready);
  wire [3:0]  awAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire [31:0] wData   = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0]  wStrb   = wHeld_reg ? wStrb_reg : s_axi_wstrb;

  assign doWrite = awNow && wNow && !s_axi_bvalid;
  assign wMerged = wData;
  assign waitCmd = doWrite && (awAddr == `ADDR_WAIT_CMD) &&
                   wStrb[0] && wData[`WAIT_BIT];

  // Wake inputs keep working while the core clock is suspended
  assign wakeEvent = (|interruptIn) | nmiIn | cold_reset_in;

  always @(posedge clk) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr == `ADDR_STATUS || awAddr == `ADDR_DEBUG_CTL ||
            awAddr == `ADDR_WAIT_CMD) begin
          s_axi_bresp <= `RESP_OKAY;
        end else if (awAddr == `ADDR_STATE) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld_reg <= 1'b1;
          awAddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld_reg <= 1'b1;
          wData_reg <= s_axi_wdata;
          wStrb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Control bits; only the documented positions are writable
  always @(posedge clk) begin
    if (!reset_n) begin
      status_reg   <= `STATUS_RESET;
      debugCtl_reg <= `DEBUG_RESET;
    end else if (doWrite) begin
      if (awAddr == `ADDR_STATUS) begin
        status_reg <= mergeBytes(status_reg, wMerged, wStrb) &
                      `STATUS_MASK;
      end else if (awAddr == `ADDR_DEBUG_CTL) begin
        debugCtl_reg <= mergeBytes(debugCtl_reg, wMerged, wStrb) &
                        `DEBUG_MASK;
      end
    end
  end

  // Wait halt: wake beats a wait command in the same cycle
  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= RUN;
    end else begin
      case (state_reg)
        RUN: begin
          if (waitCmd && !wakeEvent) begin
            state_reg <= HALT;
          end
        end
        HALT: begin
          if (wakeEvent) begin
            state_reg <= RUN;
          end
        end
        default: state_reg <= RUN;
      endcase
    end
  end

  // Reads; the state word shows only the halt, in bit 0
  always @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      if (s_axi_araddr == `ADDR_STATUS) begin
        s_axi_rdata <= status_reg;
      end else if (s_axi_araddr == `ADDR_DEBUG_CTL) begin
        s_axi_rdata <= debugCtl_reg;
      end else if (s_axi_araddr == `ADDR_WAIT_CMD) begin
        s_axi_rdata <= 32'h00000000;
      end else if (s_axi_araddr == `ADDR_STATE) begin
        s_axi_rdata <= {31'h00000000, state_reg};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Outputs straight from register bits, so they track every change
  assign low_power_request_out = status_reg[`LOW_POWER_POS];
  assign exception_level_out   = status_reg[`EXC_LEVEL_POS];
  assign error_level_out       = status_reg[`ERR_LEVEL_POS];
  assign debug_mode_out        = debugCtl_reg[`DEBUG_MODE_POS];
  assign sleepOut              = state_reg;
  // Gate enable for the core clock; this block stays on the free clock
  // and holds all state in flops, so a slowed clock loses nothing
  assign coreClockEnable       = !state_reg;

endmodule
`default_nettype wire

// ### src/power_state_defs.vh
// Register map, field positions and reset values of the power-state block
`ifndef POWER_STATE_DEFS_VH
`define POWER_STATE_DEFS_VH

// Byte addresses on the AXI4-Lite slave
`define ADDR_STATUS     4'h0
`define ADDR_DEBUG_CTL  4'h4
`define ADDR_WAIT_CMD   4'h8
`define ADDR_STATE      4'hc

// Field positions
`define LOW_POWER_POS  27
`define EXC_LEVEL_POS  1
`define ERR_LEVEL_POS  2
`define DEBUG_MODE_POS 30
`define WAIT_BIT 0

// Masks of writable bits
`define STATUS_MASK 32'h08000006
`define DEBUG_MASK  32'h40000000

// Reset values
`define STATUS_RESET 32'h00000000
`define DEBUG_RESET  32'h00000000

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verification/power_state_props.sv
// Assertion checker on the power-state block ports
`timescale 1ns/100ps
`default_nettype none
module power_state_props #(parameter INT_COUNT = 6) (
  input wire logic clk, reset_n, nmiIn, cold_reset_in,
  input wire logic [INT_COUNT-1:0] interruptIn,
  input wire logic [3:0] s_axi_awaddr, s_axi_wstrb,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic low_power_request_out, exception_level_out,
  input wire logic error_level_out, debug_mode_out, sleepOut, coreClockEnable
);
  logic wr, wake;
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wake = |interruptIn || nmiIn || cold_reset_in;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_lowpow_mirror: assert property (wr && s_axi_awaddr == 4'h0
    && s_axi_wstrb[3] |=> low_power_request_out == $past(s_axi_wdata[27]))
    else $error("low power mirror");
  a_exclev_mirror: assert property (wr && s_axi_awaddr == 4'h0
    && s_axi_wstrb[0] |=> exception_level_out == $past(s_axi_wdata[1]))
    else $error("exception level mirror");
  a_errlev_mirror: assert property (wr && s_axi_awaddr == 4'h0
    && s_axi_wstrb[0] |=> error_level_out == $past(s_axi_wdata[2]))
    else $error("error level mirror");
  a_debug_mirror: assert property (wr && s_axi_awaddr == 4'h4
    && s_axi_wstrb[3] |=> debug_mode_out == $past(s_axi_wdata[30]))
    else $error("debug mirror");
  a_mirror_hold: assert property (!wr |=> $stable({low_power_request_out,
    exception_level_out, error_level_out, debug_mode_out})) else $error("hold");
  a_sleep_enter: assert property (wr && s_axi_awaddr == 4'h8 && !wake
    && s_axi_wstrb[0] && s_axi_wdata[0] |=> sleepOut) else $error("enter");
  a_wake_exit: assert property (sleepOut && wake |=> !sleepOut)
    else $error("wake");
  a_sleep_gate: assert property (sleepOut && !wake |=> sleepOut
    && !coreClockEnable) else $error("gate");
  cover property (sleepOut && wake);
  cover property (wr && s_axi_awaddr == 4'h8);
  cover property (exception_level_out && sleepOut);
endmodule
bind core_power_state_signalling power_state_props #(.INT_COUNT(INT_COUNT))
  power_state_props_i (.*);
`default_nettype wire

// ### verification/system_agent.sv
// System agent model: watches level outputs, wakes the halted core by NMI
`timescale 1ns/100ps
`default_nettype none
module system_agent (
  input wire logic clk, reset_n, sleepOut, low_power_request_out,
  input wire logic exception_level_out, error_level_out, debug_mode_out,
  input wire logic [3:0] wakeDelay,
  output logic nmiIn = 1'b0,
  output logic slowClock = 1'b0
);
  logic [3:0] waitCnt;
  always @(posedge clk) begin
    slowClock <= reset_n && low_power_request_out;
    if (!reset_n || !sleepOut) begin
      waitCnt <= 4'h0;
      nmiIn <= 1'b0;
    end else if (exception_level_out || error_level_out || debug_mode_out) begin
      if (waitCnt == wakeDelay) nmiIn <= 1'b1;
      else waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the power-state block and its system agent
`timescale 1ns/100ps
`default_nettype none
`include "power_state_defs.vh"
module testbench;
  logic clk = 0, reset_n = 0, nmiIn, cold_reset_in = 0, slowClock;
  logic [5:0] interruptIn = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 0, s_axi_araddr = 0;
  logic [3:0] wakeDelay = 0, strb;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, statusReg, debugReg, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, low_power_request_out;
  logic exception_level_out, error_level_out, debug_mode_out, sleepOut;
  logic coreClockEnable;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int mismatches = 0, check_count = 0, n, src;
  core_power_state_signalling core_power_state_signalling_i (.*);
  system_agent system_agent_i (.*);
  initial forever #20 clk = ~clk;
  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bound;
    if (n >= 30) begin
      mismatches++;
      $display("[FAIL] %0t no answer", $time);
      conclude;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic awDone, wDone;
    awDone = 0;
    wDone = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1;
        s_axi_awvalid <= 0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1;
        s_axi_wvalid <= 0;
      end
    end while (!(awDone && wDone) && ++n < 30);
    bound;
    n = 0; do @(posedge clk); while (!s_axi_bvalid && ++n < 30);
    bound;
    resp = s_axi_bresp; s_axi_bready <= 0;
  endtask
  task rdReg(input logic [3:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    n = 0; do @(posedge clk); while (!s_axi_arready && ++n < 30);
    bound;
    s_axi_arvalid <= 0;
    n = 0; do @(posedge clk); while (!s_axi_rvalid && ++n < 30);
    bound;
    rd = s_axi_rdata; resp = s_axi_rresp; s_axi_rready <= 0;
  endtask
  function logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[b*8 +: 8] = d[b*8 +: 8];
    return o;
  endfunction
  initial begin
    void'($urandom(32'h2378));
    repeat (3) @(posedge clk);
    reset_n <= 1;
    statusReg = 0; debugReg = 0;
    for (int i = 0; i < 16; i++) begin
      rd = $urandom; strb = $urandom;
      wr(i[0] ? 4'h4 : 4'h0, rd, strb);
      if (i[0]) debugReg = merge(debugReg, rd, strb) & `DEBUG_MASK;
      else statusReg = merge(statusReg, rd, strb) & `STATUS_MASK;
      chk(low_power_request_out, statusReg[27]);
      chk(exception_level_out, statusReg[1]);
      chk(error_level_out, statusReg[2]);
      chk(debug_mode_out, debugReg[30]);
      rdReg(i[0] ? 4'h4 : 4'h0);
      chk(rd, i[0] ? debugReg : statusReg);
      chk(slowClock, statusReg[27]);
    end
    rdReg(4'h2);
    chk(resp, `RESP_SLVERR);
    // Sources: interrupt, cold reset, agent prompt, agent slow
    for (src = 0; src < 4; src++) begin
      wr(4'h0, src > 1 ? 32'h2 : 32'h0, 4'hf);
      wakeDelay <= src == 3 ? 4'h6 : 4'h0;
      wr(4'h8, 32'h1, 4'h1);
      chk(sleepOut, 1);
      chk(coreClockEnable, 0);
      if (src < 2) begin
        rdReg(4'hc);
        chk(rd, 1);
        if (src == 0) interruptIn <= 6'h1 << ($urandom % 6);
        else cold_reset_in <= 1;
      end
      n = 0; do @(posedge clk); while (sleepOut && ++n < 30);
      bound;
      interruptIn <= 0; cold_reset_in <= 0;
      chk(coreClockEnable, 1);
      chk(exception_level_out, src > 1);
    end
    conclude;
  end
endmodule
`default_nettype wire
